// *** io_ctrl_pkg.sv ***
// Constants for the I/O port and timer cascade control register
//
// Behaviour
// - Power-down with float bit set floats ports
// - Float bit clear keeps ports driving
// - Per-port bits make ports 1-3 inputs
// - Cascade bit chains timers into 32 bits
// - Cascade carry sets timer 1 overflow flag
// - Float applies to both power-down kinds
package io_ctrl_pkg;

	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] ADDR_IO_PORT_TIMER_CONTROL = 8'hf8;
	localparam logic [7:0] ADDR_INT_STATUS = 8'hf9;
	localparam logic [7:0] ADDR_INT_MASK = 8'hfa;
	localparam logic [7:0] ADDR_TIMER0_LO = 8'hfb;
	localparam logic [7:0] ADDR_TIMER0_HI = 8'hfc;
	localparam logic [7:0] ADDR_TIMER1_LO = 8'hfd;
	localparam logic [7:0] ADDR_TIMER1_HI = 8'hfe;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int BIT_FLOAT = 0;
	localparam int BIT_PORT1_HIGH_IMPEDANCE = 1;
	localparam int BIT_PORT2_HIGH_IMPEDANCE = 2;
	localparam int BIT_PORT3_HIGH_IMPEDANCE = 3;
	localparam int BIT_PULLUP_DIS = 4;
	localparam int BIT_SERIAL_FRAMING_ERROR_FLAG = 5;
	localparam int BIT_CASCADE = 6;
	localparam int IRQ_SERIAL_FRAMING_ERROR_FLAG = 0;
	localparam int IRQ_TF1 = 1;

	// -----------------------------------------------------------------
	// Reset values and masks
	// -----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_WMASK = 8'h5f;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] IRQ_BITS = 8'h03;

endpackage

// *** timer_cascade.sv ***
// Two 16-bit timers, optionally chained into one 32-bit counter
`timescale 1ns/1ps
`default_nettype none
module timer_cascade #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic cascade,
	input wire logic run0,
	input wire logic run1,
	input wire logic [1:0] load,
	input wire logic [2*WIDTH-1:0] load_val,
	output logic [WIDTH-1:0] count0_r,
	output logic [WIDTH-1:0] count1_r,
	output logic carry1
);
	if (WIDTH < 2) begin : g_width_chk
		$error("timer width too small");
	end

	// -----------------------------------------------------------------
	// Counting
	// -----------------------------------------------------------------
	logic carry0;
	logic inc1;
	logic [WIDTH-1:0] count0_nxt;
	logic [WIDTH-1:0] count1_nxt;

	assign carry0 = run0 && (&count0_r);
	// Chained: timer 1 advances only on timer 0 carry
	assign inc1 = cascade ? carry0 : run1;
	assign carry1 = inc1 && (&count1_r);
	assign count0_nxt = load[0] ? load_val[WIDTH-1:0] :
		(run0 ? count0_r + 1'b1 : count0_r);
	assign count1_nxt = load[1] ? load_val[2*WIDTH-1:WIDTH] :
		(inc1 ? count1_r + 1'b1 : count1_r);

	always_ff @(posedge clk) begin
		if (srst) begin
			count0_r <= '0;
			count1_r <= '0;
		end else begin
			count0_r <= count0_nxt;
			count1_r <= count1_nxt;
		end
	end

	chain_step_a: assert property (@(posedge clk) disable iff (srst)
		cascade && !load[1] && !carry0 |=> $stable(count1_r))
		else $error("timer 1 moved without carry in cascade");
endmodule // timer_cascade
`default_nettype wire

// *** io_port_timer_ctrl.sv ***
// I/O port float, high-impedance and timer cascade control register
`timescale 1ns/1ps
`default_nettype none
module io_port_timer_ctrl
	import io_ctrl_pkg::*;
#(
	parameter int TIMER_WIDTH = 16
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic software_power_down,
	input wire logic hardware_power_down,
	input wire logic framing_error,
	input wire logic timer0_run,
	input wire logic timer1_run,
	input wire logic timer1_flag_clear,
	output logic timer1_overflow_flag,
	input wire logic [7:0] port0_out,
	input wire logic [7:0] port1_out,
	input wire logic [7:0] port2_out,
	input wire logic [7:0] port3_out,
	output logic [7:0] port0_o,
	output logic [7:0] port1_o,
	output logic [7:0] port2_o,
	output logic [7:0] port3_o,
	output logic [3:0] port_oe,
	output logic pullup_disable,
	output logic irq
);
	if (TIMER_WIDTH != 16) begin : g_width_chk
		$error("only 16-bit timers fit the byte register map");
	end

	// -----------------------------------------------------------------
	// Input synchroniser for the hardware power-down request pin
	// -----------------------------------------------------------------
	// Only the second stage feeds logic; the first may be metastable
	logic hpd_s1_r;
	logic hpd_s2_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			hpd_s1_r <= 1'b0;
			hpd_s2_r <= 1'b0;
		end else begin
			hpd_s1_r <= hardware_power_down;
			hpd_s2_r <= hpd_s1_r;
		end
	end

	// -----------------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	logic sel_ctrl;
	logic sel_stat;
	logic sel_mask;
	logic [3:0] sel_tmr;
	assign sel_ctrl = hit(addr, ADDR_IO_PORT_TIMER_CONTROL);
	assign sel_stat = hit(addr, ADDR_INT_STATUS);
	assign sel_mask = hit(addr, ADDR_INT_MASK);
	assign sel_tmr = {hit(addr, ADDR_TIMER1_HI), hit(addr, ADDR_TIMER1_LO),
		hit(addr, ADDR_TIMER0_HI), hit(addr, ADDR_TIMER0_LO)};

	// -----------------------------------------------------------------
	// Control register
	// -----------------------------------------------------------------
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic serial_framing_error_flag_r;
	logic serial_framing_error_flag_nxt;
	// Bit 7 and the error flag are not writable
	assign ctrl_nxt = (wr && sel_ctrl) ? (wdata & CTRL_WMASK) : ctrl_r;
	// Software may only clear the flag; a set wins over that clear
	assign serial_framing_error_flag_nxt = framing_error ? 1'b1 :
		((wr && sel_ctrl && !wdata[BIT_SERIAL_FRAMING_ERROR_FLAG]) ? 1'b0 : serial_framing_error_flag_r);

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r <= CTRL_RESET;
			serial_framing_error_flag_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			serial_framing_error_flag_r <= serial_framing_error_flag_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Port drive control
	// -----------------------------------------------------------------
	logic power_down;
	logic float_all;
	assign power_down = software_power_down || hpd_s2_r;
	assign float_all = power_down && ctrl_r[BIT_FLOAT];
	assign port_oe[0] = !float_all;
	assign port_oe[1] = !float_all && !ctrl_r[BIT_PORT1_HIGH_IMPEDANCE];
	assign port_oe[2] = !float_all && !ctrl_r[BIT_PORT2_HIGH_IMPEDANCE];
	assign port_oe[3] = !float_all && !ctrl_r[BIT_PORT3_HIGH_IMPEDANCE];
	assign pullup_disable = ctrl_r[BIT_PULLUP_DIS];

	// Registered so the port data only ever changes on a clock edge
	always_ff @(posedge clk) begin
		if (srst) begin
			port0_o <= 8'h00;
			port1_o <= 8'h00;
			port2_o <= 8'h00;
			port3_o <= 8'h00;
		end else begin
			port0_o <= port0_out;
			port1_o <= port1_out;
			port2_o <= port2_out;
			port3_o <= port3_out;
		end
	end

	// -----------------------------------------------------------------
	// Timers
	// -----------------------------------------------------------------
	logic [TIMER_WIDTH-1:0] cnt0;
	logic [TIMER_WIDTH-1:0] cnt1;
	logic carry1;
	logic [1:0] tload;
	logic [2*TIMER_WIDTH-1:0] tload_val;
	// Byte writes reload one half; the other byte keeps its count
	assign tload = {sel_tmr[3] | sel_tmr[2], sel_tmr[1] | sel_tmr[0]} &
		{2{wr}};
	assign tload_val = {sel_tmr[3] ? wdata : cnt1[15:8],
		sel_tmr[2] ? wdata : cnt1[7:0],
		sel_tmr[1] ? wdata : cnt0[15:8],
		sel_tmr[0] ? wdata : cnt0[7:0]};

	timer_cascade #(
		.WIDTH(TIMER_WIDTH)
	) u_timer (
		.clk(clk),
		.srst(srst),
		.cascade(ctrl_r[BIT_CASCADE]),
		.run0(timer0_run),
		.run1(timer1_run),
		.load(tload),
		.load_val(tload_val),
		.count0_r(cnt0),
		.count1_r(cnt1),
		.carry1(carry1)
	);

	logic tf1_r;
	logic tf1_nxt;
	// Carry of timer 1 (32-bit carry when chained) beats a clear
	assign tf1_nxt = carry1 ? 1'b1 : (timer1_flag_clear ? 1'b0 : tf1_r);
	always_ff @(posedge clk) begin
		if (srst) begin
			tf1_r <= 1'b0;
		end else begin
			tf1_r <= tf1_nxt;
		end
	end
	assign timer1_overflow_flag = tf1_r;

	// -----------------------------------------------------------------
	// Interrupt status and mask
	// -----------------------------------------------------------------
	logic [7:0] stat_r;
	logic [7:0] stat_nxt;
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic [7:0] stat_set;
	logic stat_rd;
	assign stat_set = {6'b00_0000, carry1, framing_error};
	assign stat_rd = rd && sel_stat;
	// Read clears, but an event in the read cycle stays set
	assign stat_nxt = ((stat_rd ? 8'h00 : stat_r) | stat_set) & IRQ_BITS;
	assign mask_nxt = (wr && sel_mask) ? (wdata & IRQ_BITS) : mask_r;

	always_ff @(posedge clk) begin
		if (srst) begin
			stat_r <= 8'h00;
			mask_r <= MASK_RESET;
		end else begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
		end
	end
	assign irq = |(stat_r & mask_r);

	// -----------------------------------------------------------------
	// Read data
	// -----------------------------------------------------------------
	logic [7:0] ctrl_view;
	logic [7:0] rd_mux;
	always_comb begin
		ctrl_view = ctrl_r;
		ctrl_view[BIT_SERIAL_FRAMING_ERROR_FLAG] = serial_framing_error_flag_r;
	end
	assign rd_mux = sel_ctrl ? ctrl_view :
		sel_stat ? stat_r :
		sel_mask ? mask_r :
		sel_tmr[0] ? cnt0[7:0] :
		sel_tmr[1] ? cnt0[15:8] :
		sel_tmr[2] ? cnt1[7:0] :
		sel_tmr[3] ? cnt1[15:8] : 8'h00;

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rd ? rd_mux : 8'h00;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	float_pd_a: assert property (@(posedge clk) disable iff (srst)
		software_power_down && ctrl_r[BIT_FLOAT] |-> port_oe == 4'h0)
		else $error("ports not floated in power-down");
	drive_on_a: assert property (@(posedge clk) disable iff (srst)
		!ctrl_r[BIT_FLOAT] |-> port_oe[0])
		else $error("port 0 floated with float bit clear");
	port_hz_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_r[BIT_PORT2_HIGH_IMPEDANCE] |-> !port_oe[2])
		else $error("port 2 driving while high impedance");
	port_hz1_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_r[BIT_PORT1_HIGH_IMPEDANCE] |-> !port_oe[1])
		else $error("port 1 driving while high impedance");
	port_hz3_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_r[BIT_PORT3_HIGH_IMPEDANCE] |-> !port_oe[3])
		else $error("port 3 driving while high impedance");
	drive_all_a: assert property (@(posedge clk) disable iff (srst)
		!ctrl_r[BIT_FLOAT] && ctrl_r[BIT_PORT3_HIGH_IMPEDANCE:BIT_PORT1_HIGH_IMPEDANCE] == 3'h0
		|-> port_oe == 4'hf)
		else $error("port floated with float bit clear");
	hw_float_a: assert property (@(posedge clk) disable iff (srst)
		hpd_s2_r && ctrl_r[BIT_FLOAT] |-> port_oe == 4'h0)
		else $error("synced hardware power-down left ports driving");

	hw_pd_a: assert property (@(posedge clk) disable iff (srst)
		$rose(hardware_power_down) && ctrl_r[BIT_FLOAT]
		##1 ctrl_r[BIT_FLOAT] ##1 ctrl_r[BIT_FLOAT] && hardware_power_down
		|-> port_oe == 4'h0)
		else $error("hardware power-down did not float ports");
	chain_carry_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_r[BIT_CASCADE] && timer0_run && (&cnt0) && (&cnt1)
		&& tload == 2'b00 |=> tf1_r)
		else $error("32-bit carry did not set overflow flag");
	serial_framing_error_flag_set_a: assert property (@(posedge clk) disable iff (srst)
		framing_error |=> serial_framing_error_flag_r && stat_r[IRQ_SERIAL_FRAMING_ERROR_FLAG])
		else $error("framing error not flagged");
	cascade_hold_a: assert property (@(posedge clk) disable iff (srst)
		ctrl_r[BIT_CASCADE] && !timer0_run && tload == 2'b00
		|=> $stable(cnt1))
		else $error("cascaded timer 1 counted alone");
	tf1_hold_a: assert property (@(posedge clk) disable iff (srst)
		tf1_r && !timer1_flag_clear |=> tf1_r)
		else $error("overflow flag dropped without clear");
	stat_tf1_a: assert property (@(posedge clk) disable iff (srst)
		carry1 |=> tf1_r && stat_r[IRQ_TF1])
		else $error("timer carry not recorded");

	// Sticky flags: nothing but their own clear may drop them
	stat_sticky_a: assert property (@(posedge clk) disable iff (srst)
		stat_r[IRQ_TF1] && !stat_rd |=> stat_r[IRQ_TF1])
		else $error("status bit dropped without a read");
	serial_framing_error_flag_hold_a: assert property (@(posedge clk) disable iff (srst)
		serial_framing_error_flag_r && !(wr && sel_ctrl) |=> serial_framing_error_flag_r)
		else $error("framing flag dropped without a write");

	rd_idle_a: assert property (@(posedge clk) disable iff (srst)
		!rd |=> rdata == 8'h00)
		else $error("read data outside its read cycle");
	unmapped_rd_a: assert property (@(posedge clk) disable iff (srst)
		rd && !sel_ctrl && !sel_stat && !sel_mask && sel_tmr == 4'h0
		|=> rdata == 8'h00)
		else $error("unmapped address read non-zero");
	mask_wr_a: assert property (@(posedge clk) disable iff (srst)
		wr && sel_mask |=> mask_r == ($past(wdata) & IRQ_BITS))
		else $error("mask write not taken");
	ctrl_rsvd_a: assert property (@(posedge clk) disable iff (srst)
		rd && sel_ctrl |=> !rdata[7])
		else $error("reserved control bit read non-zero");
	rd_data_a: assert property (@(posedge clk) disable iff (srst)
		rd && sel_mask |=> rdata == $past(mask_r))
		else $error("mask read back wrong");
	irq_lvl_a: assert property (@(posedge clk) disable iff (srst)
		framing_error && mask_r[IRQ_SERIAL_FRAMING_ERROR_FLAG] && !(wr && sel_mask) |=> irq)
		else $error("unmasked event raised no interrupt");

	pd_float_c: cover property (@(posedge clk) disable iff (srst)
		float_all ##1 !float_all);
	chain_wrap_c: cover property (@(posedge clk) disable iff (srst)
		ctrl_r[BIT_CASCADE] && carry1);
	serial_framing_error_flag_irq_c: cover property (@(posedge clk) disable iff (srst)
		framing_error ##1 irq);
	hw_float_c: cover property (@(posedge clk) disable iff (srst)
		hpd_s2_r && float_all);
	tf1_clear_c: cover property (@(posedge clk) disable iff (srst)
		tf1_r && timer1_flag_clear ##1 !tf1_r);
endmodule // io_port_timer_ctrl
`default_nettype wire

// *** board_pins.sv ***
// Board-side model of the four port pin groups with pull-ups
`timescale 1ns/1ps
`default_nettype none
module board_pins (
	input wire logic clk,
	input wire logic [31:0] port_o,
	input wire logic [3:0] port_oe,
	input wire logic pullup_disable,
	output logic [31:0] pin
);
	logic [31:0] last_r;
	always_ff @(posedge clk) last_r <= pin;
	// Undriven without pull-up toggles, so a stale value never passes
	for (genvar i = 0; i < 4; i++) begin : g_pin
		assign pin[8*i+:8] = port_oe[i] ? port_o[8*i+:8] :
			pullup_disable ? ~last_r[8*i+:8] : 8'hff;
	end
endmodule // board_pins
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the I/O port and timer control register
`timescale 1ns/1ps
`default_nettype none
module testbench
	import io_ctrl_pkg::*;
;
	localparam logic [7:0] CR = ADDR_IO_PORT_TIMER_CONTROL;
	logic clk, srst, wr, rd, swpd, hwpd, ferr, run0, run1, fclr, rd_q;
	logic tf1, irq, pud;
	logic [7:0] addr, wdata, rdata;
	logic [7:0] pout [4];
	logic [7:0] po [4];
	logic [3:0] oe;
	logic [31:0] pin, seed;
	logic [7:0] expq [$];
	int n_mismatch, samples_checked;

	io_port_timer_ctrl io_port_timer_ctrl_inst (.clk(clk), .srst(srst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.software_power_down(swpd), .hardware_power_down(hwpd),
		.framing_error(ferr), .timer0_run(run0), .timer1_run(run1),
		.timer1_flag_clear(fclr), .timer1_overflow_flag(tf1),
		.port0_out(pout[0]), .port1_out(pout[1]), .port2_out(pout[2]),
		.port3_out(pout[3]), .port0_o(po[0]), .port1_o(po[1]),
		.port2_o(po[2]), .port3_o(po[3]), .port_oe(oe),
		.pullup_disable(pud), .irq(irq));
	board_pins board_pins_inst (.clk(clk),
		.port_o({po[3], po[2], po[1], po[0]}), .port_oe(oe),
		.pullup_disable(pud), .pin(pin));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic test_done();
		if (expq.size() != 0)
			n_mismatch++;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask

	// -----------------------------------------------------------------
	// Bus tasks and read monitor
	// -----------------------------------------------------------------
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		expq.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask

	always @(posedge clk) begin
		if (rd_q && expq.size() > 0)
			chk(rdata, expq.pop_front());
		rd_q <= rd;
	end

	// Kind 0: ports released, 1: interrupt, 2: overflow flag
	task automatic wait_on(input int k);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			#1;
			if ((k == 0 && oe === 4'h0) || (k == 1 && irq === 1'b1) ||
				(k == 2 && tf1 === 1'b1))
				return;
		end
		n_mismatch++;
		test_done();
	endtask

	task automatic ferr_pulse();
		@(posedge clk);
		ferr <= 1'b1;
		@(posedge clk);
		ferr <= 1'b0;
	endtask

	task automatic ld(input logic [15:0] t0, input logic [15:0] t1);
		wreg(ADDR_TIMER0_LO, t0[7:0]);
		wreg(ADDR_TIMER0_HI, t0[15:8]);
		wreg(ADDR_TIMER1_LO, t1[7:0]);
		wreg(ADDR_TIMER1_HI, t1[15:8]);
	endtask

	task automatic tick(input logic r1);
		@(posedge clk);
		run0 <= 1'b1;
		run1 <= r1;
		@(posedge clk);
		run0 <= 1'b0;
		run1 <= 1'b0;
	endtask

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		{wr, rd, swpd, hwpd, ferr, run0, run1, fclr} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		foreach (pout[i]) pout[i] = 8'h00;
		seed = 32'hef55_4133;
		srst = 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		rreg(CR, CTRL_RESET);
		rreg(ADDR_INT_MASK, MASK_RESET);
		rreg(8'h10, 8'h00);
		foreach (pout[i]) begin
			seed = lfsr(seed);
			pout[i] <= seed[7:0];
		end
		repeat (2) @(posedge clk);
		#1;
		chk(oe, 4'hf);
		chk(pin, {pout[3], pout[2], pout[1], pout[0]});
		wreg(CR, 8'hff);
		rreg(CR, 8'h5f);
		#1;
		chk(oe, 4'h1);
		chk(pud, 1'b1);
		wreg(CR, 8'h0e);
		#1;
		chk(pin[31:8], 24'hff_ffff);
		wreg(CR, 8'h01);
		@(posedge clk);
		swpd <= 1'b1;
		#1;
		chk(oe, 4'h0);
		chk(pin, 32'hffff_ffff);
		@(posedge clk);
		swpd <= 1'b0;
		hwpd <= 1'b1;
		wait_on(0);
		@(posedge clk);
		hwpd <= 1'b0;
		wreg(CR, 8'h00);
		@(posedge clk);
		swpd <= 1'b1;
		hwpd <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk(oe, 4'hf);
		@(posedge clk);
		swpd <= 1'b0;
		hwpd <= 1'b0;
		wreg(ADDR_INT_MASK, 8'h01);
		ferr_pulse();
		wait_on(1);
		rreg(CR, 8'h20);
		rreg(ADDR_INT_STATUS, 8'h01);
		repeat (2) @(posedge clk);
		#1;
		chk(irq, 1'b0);
		wreg(CR, 8'h00);
		rreg(CR, 8'h00);
		wreg(ADDR_INT_MASK, 8'h00);
		ferr_pulse();
		repeat (3) @(posedge clk);
		#1;
		chk(irq, 1'b0);
		rreg(ADDR_INT_STATUS, 8'h01);
		rreg(ADDR_INT_STATUS, 8'h00);
		wreg(CR, 8'h40);
		ld(16'hffff, 16'h0012);
		tick(1'b1);
		rreg(ADDR_TIMER1_LO, 8'h13);
		rreg(ADDR_TIMER0_LO, 8'h00);
		wreg(CR, 8'h00);
		ld(16'hffff, 16'h0012);
		tick(1'b0);
		rreg(ADDR_TIMER1_LO, 8'h12);
		wreg(CR, 8'h40);
		wreg(ADDR_INT_MASK, 8'h02);
		ld(16'hffff, 16'hffff);
		tick(1'b1);
		wait_on(2);
		@(posedge clk);
		#1;
		chk(irq, 1'b1);
		rreg(ADDR_INT_STATUS, 8'h02);
		rreg(ADDR_TIMER1_HI, 8'h00);
		@(posedge clk);
		fclr <= 1'b1;
		@(posedge clk);
		fclr <= 1'b0;
		#1;
		chk(tf1, 1'b0);
		repeat (2) @(posedge clk);
		test_done();
	end
endmodule // testbench
`default_nettype wire
